// >>> design/sync_burst_sram_port.sv
// flow-through synchronous burst sram port with byte writes
`timescale 1ns/1ps
`include "sram_port_cfg.svh"
module sync_burst_sram_port
  import sram_port_pkg::*;
#(
  parameter int ADDR_W        = `ADDR_W_DEF,
  parameter int FIFO_DEPTH    = `FIFO_DEPTH_DEF,
  parameter bit SINGLE_ENABLE = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:2] addr_hi,
  input  wire logic              burst_seed_bit1,
  input  wire logic              burst_seed_bit0,
  input  wire logic              proc_addr_strobe_n,
  input  wire logic              ctrl_addr_strobe_n,
  input  wire logic              burst_advance_n,
  input  wire logic              global_write_n,
  input  wire logic              byte_write_enable_n,
  input  wire logic              lane0_write_sel_n,
  input  wire logic              lane1_write_sel_n,
  input  wire logic              lane2_write_sel_n,
  input  wire logic              lane3_write_sel_n,
  input  wire logic              chip_sel_first_n,
  input  wire logic              chip_sel_second,
  input  wire logic              chip_sel_third_n,
  input  wire logic              output_enable_n,
  input  wire logic              burst_order_strap,
  input  wire logic              sleep_request,
  input  wire logic [7:0]        lane0_data_in,
  output logic [7:0]             lane0_data_out,
  output logic                   lane0_data_oe_n,
  input  wire logic              lane0_parity_in,
  output logic                   lane0_parity_out,
  output logic                   lane0_parity_oe_n,
  input  wire logic [7:0]        lane1_data_in,
  output logic [7:0]             lane1_data_out,
  output logic                   lane1_data_oe_n,
  input  wire logic              lane1_parity_in,
  output logic                   lane1_parity_out,
  output logic                   lane1_parity_oe_n,
  input  wire logic [7:0]        lane2_data_in,
  output logic [7:0]             lane2_data_out,
  output logic                   lane2_data_oe_n,
  input  wire logic              lane2_parity_in,
  output logic                   lane2_parity_out,
  output logic                   lane2_parity_oe_n,
  input  wire logic [7:0]        lane3_data_in,
  output logic [7:0]             lane3_data_out,
  output logic                   lane3_data_oe_n,
  input  wire logic              lane3_parity_in,
  output logic                   lane3_parity_out,
  output logic                   lane3_parity_oe_n,
  output logic                   sleeping,
  output logic                   write_overflow
);
  localparam int    DEPTH = 1 << ADDR_W;
  localparam int    FW    = ADDR_W + `LANES + `LANES*`LANE_W;

  // core array; one word per location, lane i in bits [9i+8:9i]
  word_t            mem [DEPTH];

  port_state_t      state_r, state_nxt;
  logic [ADDR_W-1:2] hi_r, hi_nxt;
  beat_t            seed_r, seed_nxt;
  beat_t            beat_r, beat_nxt;
  logic             first_r, first_nxt;
  word_t            dq_r, dq_nxt;
  logic             dq_oe_n_r, dq_oe_n_nxt;
  logic             ovf_r, ovf_nxt;
  logic             sleep_r, sleep_nxt;

  // pin synchronisers: two flops before any logic
  logic [1:0]       oe_sync_r;
  logic [1:0]       zz_sync_r;
  logic [1:0]       strap_sync_r;
  logic             mode_lin_r, mode_lin_nxt;
  logic [2:0]       strap_taken_r;

  logic             oe_n_s;
  logic             sleep_s;
  logic             sel;
  logic             p_go;
  logic             c_go;
  logic             wr_req;
  lane_mask_t       wr_mask;
  lane_mask_t       bw_n;
  word_t            din;
  logic [ADDR_W-1:0] acc_addr;
  logic             rd_go;
  logic             wr_go;

  logic             f_in_ready;
  logic             f_out_valid;
  logic             f_out_ready;
  logic [FW-1:0]    f_in_data;
  logic [FW-1:0]    f_out_data;
  logic [ADDR_W-1:0] d_addr;
  lane_mask_t       d_mask;
  word_t            d_word;

  // burst offset from seed and beat count in either order
  function automatic beat_t burst_ofs(input beat_t seed,
                                      input beat_t beat,
                                      input logic  linear);
    if (linear) begin
      burst_ofs = beat_t'(seed + beat); // R25
    end else begin
      burst_ofs = seed ^ beat; // R25
    end
  endfunction

  // replace only the lanes whose mask bit is set
  function automatic word_t lane_merge(input word_t      old,
                                       input word_t      upd,
                                       input lane_mask_t m);
    lane_merge = old;
    for (int i = 0; i < `LANES; i++) begin
      if (m[i]) begin
        lane_merge[i*`LANE_W +: `LANE_W] = upd[i*`LANE_W +: `LANE_W]; // R13 R16
      end
    end
  endfunction

  assign oe_n_s  = oe_sync_r[1];
  assign sleep_s = zz_sync_r[1];

  assign bw_n = {lane3_write_sel_n, lane2_write_sel_n,
                 lane1_write_sel_n, lane0_write_sel_n};
  assign din  = {lane3_parity_in, lane3_data_in,
                 lane2_parity_in, lane2_data_in,
                 lane1_parity_in, lane1_data_in,
                 lane0_parity_in, lane0_data_in}; // R13

  // single-enable package option looks only at the first enable
  assign sel = ~chip_sel_first_n &
               (SINGLE_ENABLE | (chip_sel_second & ~chip_sel_third_n)); // R5

  // processor strobe is dead while the first enable is high
  assign p_go = ~proc_addr_strobe_n & ~chip_sel_first_n; // R9
  assign c_go = ~ctrl_addr_strobe_n & ~p_go; // R9

  always_comb begin
    if (!global_write_n) begin
      wr_mask = '1; // R3
    end else if (!byte_write_enable_n) begin
      wr_mask = ~bw_n; // R2 R4
    end else begin
      wr_mask = '0;
    end
  end
  assign wr_req = |wr_mask;

  assign d_addr = f_out_data[FW-1 -: ADDR_W];
  assign d_mask = f_out_data[`LANES*`LANE_W +: `LANES];
  assign d_word = f_out_data[`LANES*`LANE_W-1:0];

  // the core is frozen in sleep, so queued writes wait there
  assign f_out_ready = (state_r != ST_SLEEP); // R11

  always_comb begin
    state_nxt = state_r;
    hi_nxt    = hi_r;
    seed_nxt  = seed_r;
    beat_nxt  = beat_r;
    first_nxt = 1'b0;
    rd_go     = 1'b0;
    wr_go     = 1'b0;
    sleep_nxt = (state_r == ST_SLEEP);
    case (state_r)
      ST_SLEEP: begin
        // second clock of exit happens through the synchroniser
        if (!sleep_s) begin
          state_nxt = ST_IDLE; // R23
        end
      end
      default: begin
        if (sleep_s) begin
          // access in flight is dropped on entry
          state_nxt = ST_SLEEP; // R11 R23
        end else if (p_go) begin
          if (sel) begin
            hi_nxt    = addr_hi; // R1 R8
            seed_nxt  = {burst_seed_bit1, burst_seed_bit0}; // R8 R20
            beat_nxt  = `BEAT_RST;
            state_nxt = ST_READ; // R22
            rd_go     = 1'b1; // R14
            first_nxt = (state_r == ST_IDLE); // R7
          end else begin
            state_nxt = ST_IDLE;
          end
        end else if (c_go) begin
          if (sel) begin
            hi_nxt   = addr_hi; // R1 R8
            seed_nxt = {burst_seed_bit1, burst_seed_bit0}; // R8 R20
            beat_nxt = `BEAT_RST; // R19
            if (wr_req) begin
              state_nxt = ST_WRITE; // R19
              wr_go     = 1'b1;
            end else begin
              state_nxt = ST_READ; // R14
              rd_go     = 1'b1;
              first_nxt = (state_r == ST_IDLE); // R7
            end
          end else begin
            state_nxt = ST_IDLE;
          end
        end else if (state_r != ST_IDLE) begin
          if (!burst_advance_n) begin
            beat_nxt = beat_t'(beat_r + 1'b1); // R21
          end
          if (wr_req) begin
            // write after a processor strobe lands here
            state_nxt = ST_WRITE; // R15
            wr_go     = 1'b1;
          end else begin
            state_nxt = ST_READ;
            rd_go     = 1'b1;
          end
        end
      end
    endcase
  end

  assign acc_addr = {hi_nxt, burst_ofs(seed_nxt, beat_nxt, mode_lin_r)}; // R20

  assign f_in_data = {acc_addr, wr_mask, din}; // R12

  always_comb begin
    ovf_nxt = wr_go & ~f_in_ready;
    if (rd_go) begin
      // a write retiring this edge is folded in so reads never see stale data
      if (f_out_valid && f_out_ready && d_addr == acc_addr) begin
        dq_nxt = lane_merge(mem[acc_addr], d_word, d_mask); // R12
      end else begin
        dq_nxt = mem[acc_addr]; // R12
      end
    end else begin
      dq_nxt = dq_r;
    end
    if (state_nxt == ST_READ && !first_nxt && !oe_n_s) begin
      dq_oe_n_nxt = 1'b0; // R6 R7
    end else begin
      dq_oe_n_nxt = `PIN_RELEASED; // R6 R17 R26
    end
  end

  // strap caught once the synchroniser holds a real sample, then held
  always_comb begin
    mode_lin_nxt = mode_lin_r;
    if (!strap_taken_r[2]) begin
      mode_lin_nxt = (strap_sync_r[1] == `STRAP_LINEAR); // R10
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oe_sync_r     <= 2'h3;
      zz_sync_r     <= 2'h0;
      strap_sync_r  <= 2'h3;
      mode_lin_r    <= 1'b0;
      strap_taken_r <= 3'h0;
    end else begin
      oe_sync_r     <= {oe_sync_r[0], output_enable_n};
      zz_sync_r     <= {zz_sync_r[0], sleep_request};
      strap_sync_r  <= {strap_sync_r[0], burst_order_strap};
      mode_lin_r    <= mode_lin_nxt;
      strap_taken_r <= {strap_taken_r[1:0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= ST_IDLE;
      hi_r      <= '0;
      seed_r    <= `BEAT_RST;
      beat_r    <= `BEAT_RST;
      first_r   <= 1'b0;
      dq_r      <= '0;
      dq_oe_n_r <= `PIN_RELEASED;
      ovf_r     <= 1'b0;
      sleep_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      hi_r      <= hi_nxt;
      seed_r    <= seed_nxt;
      beat_r    <= beat_nxt;
      first_r   <= first_nxt;
      dq_r      <= dq_nxt;
      dq_oe_n_r <= dq_oe_n_nxt;
      ovf_r     <= ovf_nxt;
      sleep_r   <= sleep_nxt;
    end
  end

  // queued writes retire one per clock into the array
  always_ff @(posedge clk) begin
    if (f_out_valid && f_out_ready) begin
      mem[d_addr] <= lane_merge(mem[d_addr], d_word, d_mask); // R16
    end
  end

  // write queue decouples the pins from the core write port
  word_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wq (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (wr_go),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  assign lane0_data_out    = dq_r[7:0];
  assign lane0_parity_out  = dq_r[8];
  assign lane1_data_out    = dq_r[16:9];
  assign lane1_parity_out  = dq_r[17];
  assign lane2_data_out    = dq_r[25:18];
  assign lane2_parity_out  = dq_r[26];
  assign lane3_data_out    = dq_r[34:27];
  assign lane3_parity_out  = dq_r[35];
  assign lane0_data_oe_n   = dq_oe_n_r;
  assign lane0_parity_oe_n = dq_oe_n_r;
  assign lane1_data_oe_n   = dq_oe_n_r;
  assign lane1_parity_oe_n = dq_oe_n_r;
  assign lane2_data_oe_n   = dq_oe_n_r;
  assign lane2_parity_oe_n = dq_oe_n_r;
  assign lane3_data_oe_n   = dq_oe_n_r;
  assign lane3_parity_oe_n = dq_oe_n_r;
  assign sleeping          = sleep_r;
  assign write_overflow    = ovf_r;
endmodule

// >>> design/sram_port_cfg.svh
// constants for the synchronous burst sram port
// Contract
// R1: address registers only on a strobe with the chip enables active
// R2: lane write selects are active low, sampled, qualified by byte write enable
// R3: global write low writes every lane, ignoring all other write selects
// R4: byte-masked write only when byte write enable is sampled low
// R5: selected when first low, second high, third low; one-enable option
// R6: output enable low drives the data pins, high releases them
// R7: output enable ignored in first clock of a read from deselect
// R8: a selected strobe loads the address and seeds the burst counter
// R9: processor strobe wins over controller strobe, ignored with first enable high
// R10: strap low picks linear order, high picks interleaved; strap is static
// R11: sleep input high puts the port to sleep, memory kept intact
// R12: input data registered; reads return data of the address just presented
// R13: each lane is eight data bits plus one parity bit under one select
// R14: single read starts on a selected strobe with both write inputs high
// R15: processor strobe write ignores write inputs first cycle, writes next cycle
// R16: unselected lanes keep their contents during a byte-masked write
// R17: data pins released whenever a write cycle is seen
// R18: controller raises output enable before driving write data
// R19: controller strobe write starts at once, advance ignored that cycle
// R20: two-bit wrapping burst counter seeded from the low address bits
// R21: advance low steps the burst counter, for reads and writes alike
// R22: processor strobe always starts a read, whatever the write inputs
// R23: two clocks to enter or leave sleep; pending accesses may be lost
// R24: controller deselects before sleep and stays idle during recovery
// R25: interleaved offset is seed xor beat, linear is seed plus beat
// R26: data pins high impedance when deselected or output enable high
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH
`define ADDR_W_DEF     19
`define LANES          4
`define BYTE_W         8
`define LANE_W         9
`define SEED_W         2
`define FIFO_DEPTH_DEF 4
`define BEAT_RST       2'h0
`define STRAP_LINEAR   1'b0
`define PIN_RELEASED   1'b1
`endif

// >>> design/sram_port_pkg.sv
// types shared by the burst sram port
`include "sram_port_cfg.svh"
package sram_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_SLEEP
  } port_state_t;
  typedef logic [`SEED_W-1:0]           beat_t;
  typedef logic [`LANES-1:0]            lane_mask_t;
  typedef logic [`LANES*`LANE_W-1:0]    word_t;
endpackage

// >>> design/word_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  store [DEPTH];
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [PW-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [PW:0]   count_r, count_nxt;
  logic          push, pop;

  assign in_ready  = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = store[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    wr_ptr_nxt = push ? bump(wr_ptr_r) : wr_ptr_r;
    rd_ptr_nxt = pop ? bump(rd_ptr_r) : rd_ptr_r;
    count_nxt  = count_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // storage has no reset; entries are only read once written
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr_r] <= in_data;
    end
  end
endmodule

// >>> verif/sram_port_chk.sv
// pin-level assertions for the burst sram port
`timescale 1ns/1ps
module sram_port_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic chip_sel_first_n,
  input wire logic chip_sel_second,
  input wire logic chip_sel_third_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic lane0_data_oe_n,
  input wire logic sleeping
);
  wire sel  = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
  wire oe_q = lane0_data_oe_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence desel_s;
    proc_addr_strobe_n && !ctrl_addr_strobe_n && !sel;
  endsequence
  sequence start_s;
    !proc_addr_strobe_n && sel;
  endsequence
  sequence cont_s;
    proc_addr_strobe_n && ctrl_addr_strobe_n && global_write_n && byte_write_enable_n;
  endsequence
  // long enough quiet for both synchronisers to settle
  sequence calm_s;
    !sleep_request && !sleeping && !output_enable_n;
  endsequence
  write_float_a: assert property (
    proc_addr_strobe_n && !ctrl_addr_strobe_n && sel && !global_write_n |=> oe_q)
    else $error("pins driven in write");
  desel_float_a: assert property (desel_s |=> oe_q) else $error("driven deselected");
  oe_float_a: assert property (output_enable_n [*3] |=> oe_q) else $error("driven, oe high");
  first_mask_a: assert property (desel_s ##1 start_s |=> oe_q) else $error("first read drove");
  burst_drive_a: assert property (
    calm_s [*2] ##1 (desel_s and calm_s) ##1 (start_s and calm_s) ##1 (cont_s and calm_s)
    |=> !oe_q) else $error("burst read not driven");
  sleep_in_a: assert property (sleep_request [*5] |=> sleeping) else $error("no sleep");
  sleep_out_a: assert property ($fell(sleep_request) ##0 !sleep_request [*5] |=> !sleeping)
    else $error("no wake");
  sleep_float_a: assert property (sleeping |-> oe_q) else $error("driven asleep");
endmodule

bind sync_burst_sram_port sram_port_chk u_chk (
  .clk(clk), .resetn(resetn), .proc_addr_strobe_n(proc_addr_strobe_n),
  .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .global_write_n(global_write_n),
  .byte_write_enable_n(byte_write_enable_n), .chip_sel_first_n(chip_sel_first_n),
  .chip_sel_second(chip_sel_second), .chip_sel_third_n(chip_sel_third_n),
  .output_enable_n(output_enable_n), .sleep_request(sleep_request),
  .lane0_data_oe_n(lane0_data_oe_n), .sleeping(sleeping));

// >>> verif/bus_host.sv
// controller-side model driving the burst port pins
`timescale 1ns/1ps
module bus_host
  import sram_port_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   dev_oe_n,
  input  wire word_t  dev_q,
  output logic [11:0] ctl,
  output logic [5:0]  addr,
  output logic        oe_pin_n,
  output logic        sleep_pin,
  output word_t       wire_val
);
  word_t host_d;
  // released bus shows a changing pattern, never the last value
  assign wire_val = dev_oe_n ? host_d : dev_q;
  initial begin
    ctl       = 12'hffe;
    addr      = 6'h0;
    oe_pin_n  = 1'b1;
    sleep_pin = 1'b0;
    host_d    = 36'h0;
  end
  task automatic cyc(input logic [11:0] c, input logic [5:0] a, input word_t d,
                     input logic oe);
    @(posedge clk);
    ctl      <= c;
    addr     <= a;
    host_d   <= (!c[8] || !c[7]) ? d : ~host_d;
    oe_pin_n <= !c[8] || !c[7] || oe;
  endtask
  task automatic nap(input int n);
    cyc(12'hbfe, 6'h0, 36'h0, 1'b1);
    sleep_pin <= 1'b1;
    repeat (n) cyc(12'hffe, 6'h0, 36'h0, 1'b1);
    sleep_pin <= 1'b0;
    repeat (6) cyc(12'hffe, 6'h0, 36'h0, 1'b1);
  endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module testbench;
  import sram_port_pkg::*;
  logic        clk, resetn, strap, dev_oe_n, sleeping, ovf;
  logic [11:0] ctl;
  logic [5:0]  addr;
  logic        oe_pin_n, sleep_pin;
  logic [31:0] rs;
  word_t       wire_val, dev_q, d, old;
  word_t       mem [64];
  int          err_total, check_count;

  bus_host u_host (.clk(clk), .dev_oe_n(dev_oe_n), .dev_q(dev_q), .ctl(ctl), .addr(addr),
    .oe_pin_n(oe_pin_n), .sleep_pin(sleep_pin), .wire_val(wire_val));
  sync_burst_sram_port #(.ADDR_W(6)) u_dut (
    .clk(clk), .resetn(resetn), .addr_hi(addr[5:2]), .burst_seed_bit1(addr[1]),
    .burst_seed_bit0(addr[0]), .proc_addr_strobe_n(ctl[11]), .ctrl_addr_strobe_n(ctl[10]),
    .burst_advance_n(ctl[9]), .global_write_n(ctl[8]), .byte_write_enable_n(ctl[7]),
    .lane3_write_sel_n(ctl[6]), .lane2_write_sel_n(ctl[5]), .lane1_write_sel_n(ctl[4]),
    .lane0_write_sel_n(ctl[3]), .chip_sel_first_n(ctl[2]), .chip_sel_second(ctl[1]),
    .chip_sel_third_n(ctl[0]), .output_enable_n(oe_pin_n), .burst_order_strap(strap),
    .sleep_request(sleep_pin), .sleeping(sleeping), .write_overflow(ovf),
    .lane0_data_in(wire_val[7:0]), .lane0_data_out(dev_q[7:0]), .lane0_data_oe_n(dev_oe_n),
    .lane0_parity_in(wire_val[8]), .lane0_parity_out(dev_q[8]), .lane0_parity_oe_n(),
    .lane1_data_in(wire_val[16:9]), .lane1_data_out(dev_q[16:9]), .lane1_data_oe_n(),
    .lane1_parity_in(wire_val[17]), .lane1_parity_out(dev_q[17]), .lane1_parity_oe_n(),
    .lane2_data_in(wire_val[25:18]), .lane2_data_out(dev_q[25:18]), .lane2_data_oe_n(),
    .lane2_parity_in(wire_val[26]), .lane2_parity_out(dev_q[26]), .lane2_parity_oe_n(),
    .lane3_data_in(wire_val[34:27]), .lane3_data_out(dev_q[34:27]), .lane3_data_oe_n(),
    .lane3_parity_in(wire_val[35]), .lane3_parity_out(dev_q[35]), .lane3_parity_oe_n());
  function automatic logic [31:0] nx();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic word_t rw();
    logic [31:0] x, y;
    x = nx();
    y = nx();
    return {x[3:0], y};
  endfunction
  // lane i is {parity, data} under select bit 3+i
  function automatic word_t merge(word_t o, word_t n, logic [11:0] c);
    for (int i = 0; i < 4; i++)
      if (!c[8] || (!c[7] && !c[3+i])) o[9*i +: 9] = n[9*i +: 9];
    return o;
  endfunction
  task automatic chk(input string n, input word_t s, input word_t e);
    check_count++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic go(input logic [11:0] c, input logic [5:0] a, input word_t n, input logic oe);
    u_host.cyc(c, a, n, oe);
    #1;
  endtask
  task automatic wr(input logic [11:0] c, input logic [5:0] a, input word_t n);
    go(c, a, n, 1'b1);
    if (c[11] && !c[10] && c[2:0] == 3'b010) mem[a] = merge(mem[a], n, c);
  endtask
  task automatic rd(input logic [5:0] a);
    go(12'h7fa, a, 36'h0, 1'b1);
    go(12'hbfe, a, 36'h0, 1'b1);
    chk("read data", dev_q, mem[a]);
  endtask
  task automatic burst(input logic lin);
    logic [5:0] a;
    logic [1:0] o;
    logic [31:0] t;
    for (int s = 0; s < 4; s++) begin
      t = nx();
      a = {t[3:0], s[1:0]};
      repeat (3) go(12'hbfe, a, 36'h0, 1'b0);
      go(12'h7fa, a, 36'h0, 1'b0);
      for (int b = 0; b < 4; b++) begin
        go(b == 3 ? 12'hbfe : 12'hdfa, a, 36'h0, 1'b0);
        o = lin ? s[1:0] + b[1:0] : s[1:0] ^ b[1:0];
        chk("burst data", dev_q, mem[{a[5:2], o}]);
        chk("burst drive", dev_oe_n, b == 0);
      end
      go(12'hffe, a, 36'h0, 1'b1);
      chk("released", dev_oe_n, 1'b1);
    end
    repeat (4) go(12'hffe, 6'h0, 36'h0, 1'b1);
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    resetn <= 1'b0;
    strap  <= s;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    logic [31:0] r;
    resetn = 1'b0;
    strap = 1'b0;
    rs = 32'h8b9c;
    err_total = 0;
    check_count = 0;
    do_reset(1'b0);
    #1;
    chk("oe after reset", dev_oe_n, 1'b1);
    chk("data after reset", dev_q, 36'h0);
    chk("status after reset", {sleeping, ovf}, 2'b00);
    for (int a = 0; a < 64; a++) wr(12'hafa, a[5:0], rw());
    for (int s = 0; s < 8; s++) begin
      wr({8'haf, 1'b1, s[2:0]}, 6'h28 + s[5:0], rw());
      rd(6'h28 + s[5:0]);
    end
    for (int i = 0; i < 60; i++) begin
      r = nx();
      wr({2'b10, r[0], r[1] | r[7], r[2], r[6:3], 3'b010}, r[15:10], rw());
      rd(r[15:10]);
    end
    for (int i = 0; i < 4; i++) begin
      r = nx();
      old = mem[r[5:0]];
      d = rw();
      go({2'b00, r[6], 1'b0, r[7], r[11:8], 3'b010}, r[5:0], rw(), 1'b1);
      go(12'hefa, r[5:0], d, 1'b1);
      chk("strobe read", dev_q, old);
      mem[r[5:0]] = d;
      rd(r[5:0]);
    end
    // strap low selects linear order
    burst(1'b1);
    // back-to-back writes through the queue, then read each back
    for (int i = 0; i < 4; i++) begin
      wr(12'hafa, 6'h10 + i[5:0], rw());
      chk("write float", dev_oe_n, 1'b1);
      chk("no overflow", ovf, 1'b0);
    end
    for (int i = 0; i < 4; i++) rd(6'h10 + i[5:0]);
    u_host.nap(8);
    rd(6'h05);
    chk("awake", sleeping, 1'b0);
    do_reset(1'b1);
    #1;
    chk("data after second reset", dev_q, 36'h0);
    chk("oe after second reset", dev_oe_n, 1'b1);
    // strap high selects interleaved order
    burst(1'b0);
    end_of_test();
  end
endmodule
